/* File: common/irc_consts.svh */
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

// Register indices; byte address is four times the index
`define IRC_IDX_BASE_HI       8'h60
`define IRC_IDX_BASE_LO       8'h61
`define IRC_IDX_SLOW_CLK      8'hF0
`define IRC_IDX_ROUTE_AB      8'hF4
`define IRC_IDX_ROUTE_CD      8'hF5

`define IRC_ADDR_W            10
`define IRC_DATA_W            32

// Reset values
`define IRC_RST_BASE_HI       8'h00
`define IRC_RST_BASE_LO       8'h00
`define IRC_RST_SLOW_CLK      8'h00
`define IRC_RST_ROUTE         8'h00

// Writable bits of the base registers; bit positions in the slow clock register
`define IRC_MASK_BASE_HI      8'h0F
`define IRC_MASK_BASE_LO      8'hF8
`define IRC_BIT_CLK_ABSENT    0
`define IRC_BIT_KEY_OFF       1

// Permitted window base range
`define IRC_BASE_MIN          16'h0100
`define IRC_BASE_MAX          16'h0FF8

// Slow clock presence timing
`define IRC_CLK_PERIOD_NS     25
`define IRC_SLOW_PERIOD_NS    31250
`define IRC_SLOW_TIMEOUT_CYC  ((2 * `IRC_SLOW_PERIOD_NS + `IRC_CLK_PERIOD_NS - 1) / `IRC_CLK_PERIOD_NS)
`define IRC_SLOW_CNT_W        12

`endif

/* File: common/irc_pkg.sv */
package irc_pkg;

   typedef enum logic [0:0] {
      IRC_BUS_IDLE = 1'b0,
      IRC_BUS_ACK  = 1'b1
   } irc_bus_state_t;

   typedef struct packed {
      logic       read;
      logic       write;
      logic [9:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } irc_avs_req_t;

   typedef struct packed {
      logic [3:0] hi;
      logic [3:0] lo;
   } irc_route_t;

endpackage

/* File: verilog/irc_route_slot.sv */
`timescale 1ns/1ps
`include "irc_consts.svh"

module irc_route_slot
   import irc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        int_in,
   input  wire logic [3:0]  route_in,
   output logic      [15:0] irq_vec_out
);

   logic        sync1_reg;
   logic        sync2_reg;
   logic [15:0] vec_reg;
   logic [15:0] vec_next;

   always_comb begin
      vec_next = 16'h0000;
      if (route_in != 4'h0) begin
         vec_next[route_in] = sync2_reg;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         vec_reg   <= 16'h0000;
      end else begin
         sync1_reg <= int_in;
         sync2_reg <= sync1_reg;
         vec_reg   <= vec_next;
      end
   end

   assign irq_vec_out = vec_reg;

   a_route_none_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (route_in == 4'h0) |=> (vec_reg == 16'h0000))
      else $error("route code zero drove an interrupt");

   a_route_decode_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (route_in != 4'h0 && sync2_reg) |=> (vec_reg == (16'h0001 << $past(route_in))))
      else $error("routed input missed its interrupt number");

endmodule

/* File: verilog/irc_config_regs.sv */
// Contract
// - bit0 reads 1 when slow clock absent
// - bit1 set turns off, gates key-wake logic
// - route register one high nibble routes B
// - route register one low nibble routes A
// - route register two high nibble routes D
// - route register two low nibble routes C
// - code zero none, codes 1-15 that interrupt
// - base outside range ignores its cycles
`timescale 1ns/1ps
`include "irc_consts.svh"

module irc_config_regs
   import irc_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        soft_rst_in,
   input  wire logic [9:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        slow_clock_input_in,
   input  wire logic        ext_int_in_a_in,
   input  wire logic        ext_int_in_b_in,
   input  wire logic        ext_int_in_c_in,
   input  wire logic        ext_int_in_d_in,
   input  wire logic        io_cycle_in,
   input  wire logic [15:0] io_addr_in,
   output logic      [15:0] serirq_req_out,
   output logic             key_wake_logic_off_out,
   output logic             key_wake_clk_out,
   output logic             mgmt_bus_claim_out
);

   irc_avs_req_t   req;
   irc_bus_state_t bus_state_reg;
   irc_bus_state_t bus_state_next;
   logic           wait_reg;
   logic           wait_next;
   logic [31:0]    rdata_reg;
   logic [31:0]    rdata_next;
   logic [7:0]     rd_byte;
   logic           word_ok;
   logic [7:0]     idx;
   logic           wr_fire;

   logic [7:0]     base_hi_reg;
   logic [7:0]     base_hi_next;
   logic [7:0]     base_lo_reg;
   logic [7:0]     base_lo_next;
   logic           key_off_reg;
   logic           key_off_next;
   irc_route_t     route_ab_reg;
   irc_route_t     route_ab_next;
   irc_route_t     route_cd_reg;
   irc_route_t     route_cd_next;

   logic           srst_s1_reg;
   logic           srst_s2_reg;
   logic           slow_s1_reg;
   logic           slow_s2_reg;
   logic           slow_s3_reg;
   logic [11:0]    slow_cnt_reg;
   logic [11:0]    slow_cnt_next;
   logic           absent_reg;
   logic           absent_next;
   logic           key_clk_reg;
   logic           key_clk_next;

   logic [15:0]    base;
   logic           base_valid;
   logic           claim_reg;
   logic           claim_next;

   logic [15:0]    vec_a;
   logic [15:0]    vec_b;
   logic [15:0]    vec_c;
   logic [15:0]    vec_d;
   logic [15:0]    serirq_reg;
   logic [15:0]    serirq_next;

   localparam logic [11:0] SLOW_TIMEOUT = 12'(`IRC_SLOW_TIMEOUT_CYC);

   assign req = {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, avs_byteenable_in};

   assign idx     = req.addr[9:2];
   assign word_ok = (req.addr[1:0] == 2'b00);
   assign wr_fire = (bus_state_reg == IRC_BUS_ACK) && req.write && req.be[0] && word_ok;

   // Read decode; unmapped returns zero
   always_comb begin
      rd_byte = 8'h00;
      if (word_ok) begin
         case (idx)
            `IRC_IDX_BASE_HI:  rd_byte = base_hi_reg;
            `IRC_IDX_BASE_LO:  rd_byte = base_lo_reg;
            `IRC_IDX_SLOW_CLK: rd_byte = {6'h00, key_off_reg, absent_reg};
            `IRC_IDX_ROUTE_AB: rd_byte = route_ab_reg;
            `IRC_IDX_ROUTE_CD: rd_byte = route_cd_reg;
            default:           rd_byte = 8'h00;
         endcase
      end
   end

   // Bus handshake: one wait cycle, then one ack cycle
   always_comb begin
      bus_state_next = bus_state_reg;
      wait_next      = 1'b1;
      rdata_next     = rdata_reg;
      case (bus_state_reg)
         IRC_BUS_IDLE: begin
            if (req.read || req.write) begin
               bus_state_next = IRC_BUS_ACK;
               wait_next      = 1'b0;
               rdata_next     = {24'h000000, rd_byte};
            end
         end
         IRC_BUS_ACK: begin
            bus_state_next = IRC_BUS_IDLE;
         end
         default: begin
            bus_state_next = IRC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_state_reg <= IRC_BUS_IDLE;
         wait_reg      <= 1'b1;
         rdata_reg     <= 32'h00000000;
      end else begin
         bus_state_reg <= bus_state_next;
         wait_reg      <= wait_next;
         rdata_reg     <= rdata_next;
      end
   end

   // Register writes; base also clears on soft reset
   always_comb begin
      base_hi_next  = base_hi_reg;
      base_lo_next  = base_lo_reg;
      key_off_next  = key_off_reg;
      route_ab_next = route_ab_reg;
      route_cd_next = route_cd_reg;
      if (wr_fire) begin
         case (idx)
            `IRC_IDX_BASE_HI:  base_hi_next = req.wdata[7:0] & `IRC_MASK_BASE_HI;
            `IRC_IDX_BASE_LO:  base_lo_next = req.wdata[7:0] & `IRC_MASK_BASE_LO;
            `IRC_IDX_SLOW_CLK: key_off_next = req.wdata[`IRC_BIT_KEY_OFF];
            `IRC_IDX_ROUTE_AB: route_ab_next = req.wdata[7:0];
            `IRC_IDX_ROUTE_CD: route_cd_next = req.wdata[7:0];
            default: begin
            end
         endcase
      end
      if (srst_s2_reg) begin
         base_hi_next = `IRC_RST_BASE_HI;
         base_lo_next = `IRC_RST_BASE_LO;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         base_hi_reg  <= `IRC_RST_BASE_HI;
         base_lo_reg  <= `IRC_RST_BASE_LO;
         key_off_reg  <= 1'b0;
         route_ab_reg <= `IRC_RST_ROUTE;
         route_cd_reg <= `IRC_RST_ROUTE;
      end else begin
         base_hi_reg  <= base_hi_next;
         base_lo_reg  <= base_lo_next;
         key_off_reg  <= key_off_next;
         route_ab_reg <= route_ab_next;
         route_cd_reg <= route_cd_next;
      end
   end

   // Slow clock presence: absent after two periods without an edge
   always_comb begin
      slow_cnt_next = slow_cnt_reg;
      absent_next   = absent_reg;
      if (slow_s2_reg != slow_s3_reg) begin
         slow_cnt_next = 12'h000;
         absent_next   = 1'b0;
      end else if (slow_cnt_reg >= SLOW_TIMEOUT) begin
         absent_next   = 1'b1;
      end else begin
         slow_cnt_next = slow_cnt_reg + 12'h001;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         srst_s1_reg  <= 1'b0;
         srst_s2_reg  <= 1'b0;
         slow_s1_reg  <= 1'b0;
         slow_s2_reg  <= 1'b0;
         slow_s3_reg  <= 1'b0;
         slow_cnt_reg <= 12'h000;
         absent_reg   <= 1'b0;
         key_clk_reg  <= 1'b0;
      end else begin
         srst_s1_reg  <= soft_rst_in;
         srst_s2_reg  <= srst_s1_reg;
         slow_s1_reg  <= slow_clock_input_in;
         slow_s2_reg  <= slow_s1_reg;
         slow_s3_reg  <= slow_s2_reg;
         slow_cnt_reg <= slow_cnt_next;
         absent_reg   <= absent_next;
         key_clk_reg  <= key_clk_next;
      end
   end

   assign key_clk_next = slow_s2_reg & ~key_off_reg;

   // Management bus window decode
   assign base       = {4'h0, base_hi_reg[3:0], base_lo_reg[7:3], 3'b000};
   assign base_valid = (base >= `IRC_BASE_MIN) && (base <= `IRC_BASE_MAX);
   assign claim_next = io_cycle_in && base_valid && (io_addr_in[15:3] == base[15:3]);

   irc_route_slot u_slot_a (
      .clk_in      (core_clk_in),
      .rst_n_in    (rst_n_in),
      .int_in      (ext_int_in_a_in),
      .route_in    (route_ab_reg.lo),
      .irq_vec_out (vec_a)
   );

   irc_route_slot u_slot_b (
      .clk_in      (core_clk_in),
      .rst_n_in    (rst_n_in),
      .int_in      (ext_int_in_b_in),
      .route_in    (route_ab_reg.hi),
      .irq_vec_out (vec_b)
   );

   irc_route_slot u_slot_c (
      .clk_in      (core_clk_in),
      .rst_n_in    (rst_n_in),
      .int_in      (ext_int_in_c_in),
      .route_in    (route_cd_reg.lo),
      .irq_vec_out (vec_c)
   );

   irc_route_slot u_slot_d (
      .clk_in      (core_clk_in),
      .rst_n_in    (rst_n_in),
      .int_in      (ext_int_in_d_in),
      .route_in    (route_cd_reg.hi),
      .irq_vec_out (vec_d)
   );

   assign serirq_next = vec_a | vec_b | vec_c | vec_d;

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         serirq_reg <= 16'h0000;
         claim_reg  <= 1'b0;
      end else begin
         serirq_reg <= serirq_next;
         claim_reg  <= claim_next;
      end
   end

   assign avs_readdata_out       = rdata_reg;
   assign avs_waitrequest_out    = wait_reg;
   assign serirq_req_out         = serirq_reg;
   assign key_wake_logic_off_out = key_off_reg;
   assign key_wake_clk_out       = key_clk_reg;
   assign mgmt_bus_claim_out     = claim_reg;

   a_absent_after_timeout: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (slow_cnt_reg >= SLOW_TIMEOUT && slow_s2_reg == slow_s3_reg) |=> absent_reg)
      else $error("slow clock absence not flagged");

   a_present_on_edge: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (slow_s2_reg != slow_s3_reg) |=> !absent_reg)
      else $error("slow clock edge did not clear absence");

   a_key_clock_gated: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $past(key_off_reg) |-> !key_clk_reg)
      else $error("key wake clock ran while logic off");

   a_base_hi_fixed: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      base_hi_reg[7:4] == 4'h0)
      else $error("base high fixed bits not zero");

   a_base_lo_fixed: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      base_lo_reg[2:0] == 3'b000)
      else $error("base low fixed bits not zero");

   a_read_upper_zero: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (!avs_waitrequest_out && $past(idx) == `IRC_IDX_SLOW_CLK) |-> (avs_readdata_out[31:2] == 30'h0))
      else $error("reserved bits read nonzero");

   a_claim_in_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      claim_reg |-> $past(base_valid))
      else $error("cycle claimed with base out of range");

   a_claim_window: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      claim_reg |-> ($past(io_addr_in[15:3]) == $past(base[15:3])))
      else $error("cycle claimed outside window");

   a_route_b_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (route_ab_reg.hi != 4'h0 && vec_b[route_ab_reg.hi]) |=> serirq_reg[$past(route_ab_reg.hi)])
      else $error("input B not driven to its interrupt");

   a_wait_one_ack: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");

endmodule

/* File: tb/irc_config_regs_tb.sv */
`timescale 1ns/1ps
module irc_config_regs_tb;
   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic        soft_rst = 1'b0;
   logic [9:0]  addr     = 10'h000;
   logic        rd_en    = 1'b0;
   logic        wr_en    = 1'b0;
   logic [31:0] wdata    = 32'h0000_0000;
   logic [3:0]  be       = 4'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        slow_clk = 1'b0;
   logic        slow_run = 1'b1;
   logic [3:0]  ext      = 4'h0;
   logic        io_cyc   = 1'b0;
   logic [15:0] io_addr  = 16'h0000;
   logic [15:0] serirq;
   logic        key_off;
   logic        key_clk;
   logic        claim;
   int          mismatches  = 0;
   int          comparisons = 0;
   int          slow_cnt    = 0;

   always #12.5 clk = ~clk;

   // 32 kHz source, grounded while stopped
   always @(posedge clk) begin
      if (!slow_run) begin
         slow_clk <= 1'b0;
      end else if (slow_cnt == 624) begin
         slow_cnt <= 0;
         slow_clk <= ~slow_clk;
      end else begin
         slow_cnt <= slow_cnt + 1;
      end
   end

   irc_config_regs irc_config_regs_inst (
      .core_clk_in(clk), .rst_n_in(rst_n), .soft_rst_in(soft_rst),
      .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
      .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .slow_clock_input_in(slow_clk),
      .ext_int_in_a_in(ext[0]), .ext_int_in_b_in(ext[1]), .ext_int_in_c_in(ext[2]),
      .ext_int_in_d_in(ext[3]), .io_cycle_in(io_cyc), .io_addr_in(io_addr),
      .serirq_req_out(serirq), .key_wake_logic_off_out(key_off),
      .key_wake_clk_out(key_clk), .mgmt_bus_claim_out(claim));

   task automatic results();
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] b,
                      output logic [31:0] v);
      int n = 0;
      addr  <= a;
      wdata <= {24'h00_0000, d};
      be    <= b;
      wr_en <= w;
      rd_en <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      v = rdata;
      if (waitreq !== 1'b0) begin
         mismatches++;
         $display("[FAIL] %0t bus wait ran out", $time);
         results();
      end
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, 4'h1, v);
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] e, input string m);
      logic [31:0] v;
      bus(1'b0, a, 8'h00, 4'h1, v);
      check(v, {24'h00_0000, e}, m);
   endtask

   task automatic probe(input logic [15:0] a, input logic e);
      io_cyc  <= 1'b1;
      io_addr <= a;
      @(posedge clk);
      io_cyc  <= 1'b0;
      #1 check({31'h0, claim}, {31'h0, e}, "window claim");
      @(posedge clk);
   endtask

   task automatic route(input logic [9:0] a, input logic [7:0] v, input logic [3:0] e, input logic [15:0] x);
      wr(a, v);
      ext <= e;
      repeat (6) @(posedge clk);
      check({16'h0, serirq}, {16'h0, x}, "interrupt request vector");
   endtask

   task automatic edges(output int ch);
      logic prev;
      prev = key_clk;
      ch   = 0;
      repeat (1400) begin
         @(posedge clk);
         if (key_clk !== prev) ch++;
         prev = key_clk;
      end
   endtask

   task automatic t_reset();
      check({31'h0, waitreq}, 32'h1, "idle waitrequest");
      check({16'h0, serirq}, 32'h0, "vector after reset");
      rd(10'h180, 8'h00, "base high reset");
      rd(10'h184, 8'h00, "base low reset");
      rd(10'h3C0, 8'h00, "slow clock reset");
      rd(10'h3D0, 8'h00, "route ab reset");
      rd(10'h3D4, 8'h00, "route cd reset");
   endtask

   task automatic t_fields();
      logic [31:0] v;
      wr(10'h180, 8'hFF);
      rd(10'h180, 8'h0F, "base high bits");
      wr(10'h184, 8'hFF);
      rd(10'h184, 8'hF8, "base low bits");
      bus(1'b1, 10'h180, 8'h00, 4'h0, v);
      rd(10'h180, 8'h0F, "disabled byte lane");
      wr(10'h3C4, 8'hFF);
      rd(10'h3C4, 8'h00, "unmapped index");
      rd(10'h181, 8'h00, "misaligned address");
      wr(10'h3C0, 8'hFF);
      rd(10'h3C0, 8'h02, "slow clock writable bits");
      wr(10'h3C0, 8'h00);
   endtask

   task automatic t_claim();
      wr(10'h180, 8'h01);
      wr(10'h184, 8'h20);
      probe(16'h0120, 1'b1);
      probe(16'h0127, 1'b1);
      probe(16'h0128, 1'b0);
      probe(16'h011F, 1'b0);
      probe(16'h1124, 1'b0);
      wr(10'h180, 8'h0F);
      wr(10'h184, 8'hF8);
      probe(16'h0FFF, 1'b1);
      wr(10'h180, 8'h00);
      probe(16'h00F8, 1'b0);
      rd(10'h184, 8'hF8, "out of range base kept");
   endtask

   task automatic t_route();
      for (int c = 0; c < 16; c++) begin
         route(10'h3D0, {4'h0, c[3:0]}, 4'h1, (c == 0) ? 16'h0000 : (16'h0001 << c));
      end
      route(10'h3D0, 8'h70, 4'h2, 16'h0080);
      route(10'h3D4, 8'h0C, 4'h4, 16'h1000);
      route(10'h3D4, 8'h30, 4'h8, 16'h0008);
      // Interrupt 2 used by input C, management interrupt assumed off
      wr(10'h3D0, 8'h93);
      route(10'h3D4, 8'hE2, 4'hF, 16'h420C);
      route(10'h3D4, 8'hE2, 4'h0, 16'h0000);
      rd(10'h3D0, 8'h93, "route ab readback");
      rd(10'h3D4, 8'hE2, "route cd readback");
   endtask

   task automatic t_slow();
      int ch;
      edges(ch);
      check({31'h0, ch > 0}, 32'h1, "gated clock runs");
      wr(10'h3C0, 8'h02);
      check({31'h0, key_off}, 32'h1, "key logic off");
      repeat (4) @(posedge clk);
      edges(ch);
      check(ch, 32'h0, "gated clock stopped");
      check({31'h0, key_clk}, 32'h0, "gated clock low");
      wr(10'h3C0, 8'h00);
      slow_run <= 1'b0;
      repeat (2700) @(posedge clk);
      rd(10'h3C0, 8'h01, "slow clock absent");
      slow_run <= 1'b1;
      repeat (1400) @(posedge clk);
      rd(10'h3C0, 8'h00, "slow clock present");
   endtask

   task automatic t_soft();
      wr(10'h180, 8'h0A);
      soft_rst <= 1'b1;
      repeat (5) @(posedge clk);
      soft_rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(10'h180, 8'h00, "soft reset base high");
      rd(10'h184, 8'h00, "soft reset base low");
      rd(10'h3D0, 8'h93, "soft reset keeps routes");
      // Mid-run power reset clears every register
      wr(10'h3C0, 8'h02);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(10'h3D0, 8'h00, "power reset route ab");
      rd(10'h3D4, 8'h00, "power reset route cd");
      rd(10'h3C0, 8'h00, "power reset slow clock");
      check({31'h0, key_off}, 32'h0, "power reset key logic on");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_fields();
      t_claim();
      t_route();
      t_slow();
      t_soft();
      results();
   end
endmodule
